// ### logic/pbs_pkg.sv
// Shared constants and types for the burst memory port
package pbs_pkg;
  localparam int PBS_AW = 16;
  localparam int PBS_LANES = 4;
  localparam int PBS_LANE_W = 9;
  localparam int PBS_DW = PBS_LANES * PBS_LANE_W;
  localparam int PBS_FIFO_DEPTH = 16;
  localparam int PBS_SLEEP_IN_CYCLES = 2;
  localparam int PBS_WAKE_CYCLES = 2;
  localparam logic [1:0] PBS_CNT_RESET = 2'h0;
  localparam logic [PBS_LANES-1:0] PBS_ALL_LANES = 4'hf;
  localparam logic [PBS_LANES-1:0] PBS_NO_LANES = 4'h0;
  localparam logic [PBS_DW-1:0] PBS_DATA_RESET = 36'h0;
  localparam logic [PBS_AW-1:0] PBS_ADDR_RESET = 16'h0;

  typedef enum logic [2:0]
  {
    PBS_ST_DESEL = 3'h1,
    PBS_ST_BURST = 3'h2,
    PBS_ST_SLEEP = 3'h4
  } pbs_state_t;

  typedef struct packed
  {
    logic [PBS_AW-1:0] addr;
    logic [PBS_LANES-1:0] lanes;
    logic [PBS_DW-1:0] data;
  } pbs_wr_t;

  localparam int PBS_WR_W = $bits(pbs_wr_t);
endpackage

// ### logic/pbs_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides
module pbs_fifo
  import pbs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pbs_fifo_state_t;

  pbs_fifo_state_t q;
  pbs_fifo_state_t next_q;
  logic push;
  logic pop;

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_q = q;
    if (push)
    begin
      next_q.mem[q.wp] = in_data;
      next_q.wp = q.wp + 1'b1;
    end
    if (pop)
    begin
      next_q.rp = q.rp + 1'b1;
    end
    next_q.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule

// ### logic/pbs_port.sv
// Synchronous pipelined burst memory port with sleep and output control
// Function
// - Sleep high deselects the port and ignores all other inputs.
// - Sleep input is asynchronous, active high, held sleep while high.
// - Inputs are ignored no later than two clocks after sleep rises.
// - Output enable drives nothing before the second edge after a first read.
// - Data outputs go high impedance within two cycles of deselect.
// - Global write low, or gate and all lane strobes low, writes all lanes.
// - After a write the bus stays released until a strobe or step cycle.
// - Back-to-back reads start with either address strobe.
// - Selected only with primary low, second low and high select high.
// - Later beats of a burst use the internal counter address.
// - Write needs global write low or a gated lane strobe low, and cpu strobe high; else read.
module pbs_port
  import pbs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sleep_request,
  input wire logic [PBS_AW-1:0] address,
  input wire logic chip_select_n,
  input wire logic chip_select_b_n,
  input wire logic chip_select_b_hi,
  input wire logic load_strobe_cpu_n,
  input wire logic load_strobe_ctl_n,
  input wire logic burst_step_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [PBS_LANES-1:0] byte_lane_write_n,
  input wire logic output_enable_n,
  input wire logic burst_order_linear,
  input wire logic [PBS_DW-1:0] dq_in,
  output logic [PBS_DW-1:0] dq_out,
  output logic dq_oe,
  output logic sleep_active,
  output logic write_buffer_ready,
  output logic core_rd_en,
  output logic [PBS_AW-1:0] core_rd_addr,
  input wire logic [PBS_DW-1:0] core_rd_data,
  output logic core_wr_valid,
  input wire logic core_wr_ready,
  output pbs_wr_t core_wr
);
  typedef struct packed
  {
    logic sync1;
    logic sync2;
    pbs_state_t st;
    logic [PBS_AW-1:0] base;
    logic [1:0] cnt;
    logic rd_pend;
    logic wr_last;
    logic [PBS_AW-1:0] rd_addr;
    logic drive;
    logic [PBS_DW-1:0] dout;
  } pbs_port_state_t;

  pbs_port_state_t q;
  pbs_port_state_t next_q;
  logic asleep;
  logic sel;
  logic wr_any;
  logic [PBS_LANES-1:0] wr_lanes;
  logic load;
  logic desel;
  logic cont;
  logic step;
  logic is_wr;
  logic rd_issue;
  logic wr_req;
  logic wr_push;
  logic [1:0] low_addr;
  logic [PBS_AW-1:0] acc_addr;
  pbs_wr_t wr_word;

  // ************************************************
  // Cycle decode
  // ************************************************
  always_comb
  begin
    asleep = q.sync2;
    sel = !chip_select_n && !chip_select_b_n && chip_select_b_hi;
    wr_any = !global_write_n || (!byte_write_gate_n && (byte_lane_write_n != PBS_ALL_LANES));
    if (!global_write_n)
    begin
      wr_lanes = PBS_ALL_LANES;
    end
    else if (!byte_write_gate_n)
    begin
      wr_lanes = ~byte_lane_write_n;
    end
    else
    begin
      wr_lanes = PBS_NO_LANES;
    end
    load = !asleep && sel && (!load_strobe_cpu_n || !load_strobe_ctl_n);
    desel = !asleep && !sel && (!load_strobe_cpu_n || !load_strobe_ctl_n);
    cont = !asleep && load_strobe_cpu_n && load_strobe_ctl_n && q.st == PBS_ST_BURST;
    step = cont && !burst_step_n;
    is_wr = load_strobe_cpu_n && wr_any;
    rd_issue = (load || step || (cont && !q.wr_last)) && !is_wr;
    wr_req = (load || cont) && is_wr;
    wr_push = wr_req && write_buffer_ready;
    next_q = q;
    next_q.sync1 = sleep_request;
    next_q.sync2 = q.sync1;
    if (load)
    begin
      next_q.base = address;
      next_q.cnt = PBS_CNT_RESET;
    end
    else if (step)
    begin
      next_q.cnt = q.cnt + 2'h1;
    end
    if (burst_order_linear)
    begin
      low_addr = next_q.base[1:0] + next_q.cnt;
    end
    else
    begin
      low_addr = next_q.base[1:0] ^ next_q.cnt;
    end
    acc_addr = {next_q.base[PBS_AW-1:2], low_addr};
    case (q.st)
      PBS_ST_SLEEP:
      begin
        if (asleep)
        begin
          next_q.st = PBS_ST_SLEEP;
        end
        else if (load)
        begin
          next_q.st = PBS_ST_BURST;
        end
        else
        begin
          next_q.st = PBS_ST_DESEL;
        end
      end
      PBS_ST_DESEL, PBS_ST_BURST:
      begin
        if (asleep)
        begin
          next_q.st = PBS_ST_SLEEP;
        end
        else if (desel)
        begin
          next_q.st = PBS_ST_DESEL;
        end
        else if (load)
        begin
          next_q.st = PBS_ST_BURST;
        end
      end
      default:
      begin
        next_q.st = PBS_ST_DESEL;
      end
    endcase
    // ************************************************
    // Read pipeline and output drive
    // ************************************************
    next_q.rd_pend = rd_issue;
    // Suspend cycles after a write keep the bus released
    if (wr_req)
    begin
      next_q.wr_last = 1'b1;
    end
    else if (load || step)
    begin
      next_q.wr_last = 1'b0;
    end
    if (rd_issue)
    begin
      next_q.rd_addr = acc_addr;
    end
    next_q.drive = q.rd_pend && !asleep;
    if (q.rd_pend)
    begin
      next_q.dout = core_rd_data;
    end
    wr_word.addr = acc_addr;
    wr_word.lanes = wr_lanes;
    wr_word.data = dq_in;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q.sync1 <= 1'b0;
      q.sync2 <= 1'b0;
      q.st <= PBS_ST_DESEL;
      q.base <= PBS_ADDR_RESET;
      q.cnt <= PBS_CNT_RESET;
      q.rd_pend <= 1'b0;
      q.wr_last <= 1'b0;
      q.rd_addr <= PBS_ADDR_RESET;
      q.drive <= 1'b0;
      q.dout <= PBS_DATA_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign dq_out = q.dout;
  assign dq_oe = q.drive && !output_enable_n;
  assign sleep_active = q.st == PBS_ST_SLEEP;
  assign core_rd_en = q.rd_pend;
  assign core_rd_addr = q.rd_addr;

  // ************************************************
  // Write buffer toward the core
  // ************************************************
  pbs_fifo #(.WIDTH(PBS_WR_W), .DEPTH(PBS_FIFO_DEPTH)) u_wr_fifo
  (
    .mclk(mclk),
    .rst(rst),
    .in_valid(wr_req),
    .in_ready(write_buffer_ready),
    .in_data(wr_word),
    .out_valid(core_wr_valid),
    .out_ready(core_wr_ready),
    .out_data(core_wr)
  );

  // ************************************************
  // Checks
  // ************************************************
  a_sleep_ignores: assert property (@(posedge mclk) disable iff (rst)
    sleep_request [*2] |=> !wr_push && !rd_issue)
    else $error("Inputs accepted two clocks after sleep rose");
  a_sleep_state: assert property (@(posedge mclk) disable iff (rst)
    sleep_request [*3] |=> ##1 sleep_active && !dq_oe)
    else $error("Sleep state not held while sleep is high");
  a_first_read_hiz: assert property (@(posedge mclk) disable iff (rst)
    rd_issue && !q.rd_pend && !q.drive |=> !dq_oe)
    else $error("Bus driven before the edge after the first read");
  a_desel_release: assert property (@(posedge mclk) disable iff (rst)
    q.st == PBS_ST_DESEL [*2] |-> !dq_oe)
    else $error("Bus still driven two cycles after deselect");
  a_write_hiz: assert property (@(posedge mclk) disable iff (rst)
    wr_push && !rd_issue |-> ##2 !dq_oe)
    else $error("Bus driven after a write cycle");
  a_write_hold: assert property (@(posedge mclk) disable iff (rst)
    wr_req ##1 (!asleep && load_strobe_cpu_n && load_strobe_ctl_n && burst_step_n && !is_wr)
      |=> !core_rd_en)
    else $error("Read issued by a suspend cycle after a write");
  a_full_write: assert property (@(posedge mclk) disable iff (rst)
    wr_push && (!global_write_n || (!byte_write_gate_n && byte_lane_write_n == 4'h0))
      |-> wr_word.lanes == 4'hf)
    else $error("Full width write lost lanes");
  a_write_decode: assert property (@(posedge mclk) disable iff (rst)
    wr_push |-> load_strobe_cpu_n && wr_lanes != 4'h0)
    else $error("Write taken without a lane strobe or with cpu strobe low");
  a_select_gate: assert property (@(posedge mclk) disable iff (rst)
    !asleep && !chip_select_b_n && !chip_select_b_hi && !load_strobe_ctl_n
      |=> q.st == PBS_ST_DESEL)
    else $error("Port selected with high select low");
  a_read_start: assert property (@(posedge mclk) disable iff (rst)
    !asleep && sel && (!load_strobe_cpu_n || !load_strobe_ctl_n) && !is_wr
      |=> core_rd_en && core_rd_addr == $past(address))
    else $error("Strobe read not issued at loaded address");
  a_burst_step: assert property (@(posedge mclk) disable iff (rst)
    step |=> q.cnt == $past(q.cnt) + 2'h1)
    else $error("Burst counter did not advance");
endmodule

// ### bench/pbs_core_model.sv
// Memory core model behind the port
module pbs_core_model
  import pbs_pkg::*;
(
  input wire logic mclk,
  input wire logic stall,
  input wire logic core_rd_en,
  input wire logic [PBS_AW-1:0] core_rd_addr,
  output logic [PBS_DW-1:0] core_rd_data,
  input wire logic core_wr_valid,
  output logic core_wr_ready,
  input wire pbs_wr_t core_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PBS_DW-1:0] mem [0:255];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {20'h5a5a5, 8'h00, i[7:0]};
  end
  // Garbage unless a read is issued
  assign core_rd_data = core_rd_en ? mem[core_rd_addr[7:0]] : ~mem[core_rd_addr[7:0]];
  assign core_wr_ready = !stall;
  always @(posedge mclk)
  begin
    if (core_wr_valid && core_wr_ready)
    begin
      for (int i = 0; i < PBS_LANES; i++)
        if (core_wr.lanes[i])
          mem[core_wr.addr[7:0]][i*9 +: 9] <= core_wr.data[i*9 +: 9];
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking testbench for the burst memory port
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
  import pbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Stimulus and checks
  // ****************
  logic mclk = 1'b0, rst = 1'b1, stall = 1'b0, sleep_request = 1'b0, output_enable_n = 1'b0;
  logic chip_select_n = 1'b0, chip_select_b_n = 1'b0, chip_select_b_hi = 1'b1;
  logic load_strobe_cpu_n = 1'b1, load_strobe_ctl_n = 1'b1, burst_step_n = 1'b1;
  logic global_write_n = 1'b1, byte_write_gate_n = 1'b1, burst_order_linear = 1'b0;
  logic [3:0] byte_lane_write_n = 4'hf;
  logic [PBS_AW-1:0] address = 16'h0, core_rd_addr;
  logic [PBS_DW-1:0] dq_in = 36'h0, dq_out, core_rd_data;
  logic dq_oe, sleep_active, write_buffer_ready, core_rd_en, core_wr_valid, core_wr_ready;
  pbs_wr_t core_wr;
  int num_errors = 0, compares = 0;

  pbs_port dut (.mclk, .rst, .sleep_request, .address, .chip_select_n, .chip_select_b_n,
    .chip_select_b_hi, .load_strobe_cpu_n, .load_strobe_ctl_n, .burst_step_n, .global_write_n,
    .byte_write_gate_n, .byte_lane_write_n, .output_enable_n, .burst_order_linear, .dq_in,
    .dq_out, .dq_oe, .sleep_active, .write_buffer_ready, .core_rd_en, .core_rd_addr,
    .core_rd_data, .core_wr_valid, .core_wr_ready, .core_wr);
  pbs_core_model mem_model (.mclk, .stall, .core_rd_en, .core_rd_addr, .core_rd_data,
    .core_wr_valid, .core_wr_ready, .core_wr);

  always #10 mclk = ~mclk;

  function automatic logic [35:0] pat(input logic [15:0] a);
    return {20'h5a5a5, 8'h00, a[7:0]};
  endfunction

  // Strobes as {cpu, ctl, step, global write}
  task automatic put(input logic [3:0] c, input logic [15:0] a, input logic [35:0] d = 36'h0);
    {load_strobe_cpu_n, load_strobe_ctl_n, burst_step_n, global_write_n} <= c;
    address <= a;
    dq_in <= d;
    @(posedge mclk);
  endtask

  // Outputs read right after an edge show the state launched by the edge before
  task automatic desel();
    chip_select_n <= 1'b1;
    put(4'hb, 16'h0);
    chip_select_n <= 1'b0;
  endtask

  task automatic rd1(input logic [15:0] a, input logic [35:0] e);
    put(4'hb, a);
    desel();
    `CHK("rd_addr1", a, core_rd_addr)
    put(4'hf, a);
    `CHK("dq", e, dq_out)
    `CHK("oe_rd", 1'b1, dq_oe)
    put(4'hf, a);
    `CHK("oe_rel", 1'b0, dq_oe)
  endtask

  task automatic wr(input logic [15:0] a, input logic [35:0] d, input logic gw,
    input logic [3:0] ln);
    output_enable_n <= 1'b1;
    byte_write_gate_n <= 1'b0;
    byte_lane_write_n <= ln;
    put({3'b101, gw}, a, d);
    byte_write_gate_n <= 1'b1;
    byte_lane_write_n <= 4'hf;
    put(4'hf, a);
    output_enable_n <= 1'b0;
    desel();
    `CHK("rd_wr", 1'b0, core_rd_en)
    put(4'hf, a);
    `CHK("oe_wr", 1'b0, dq_oe)
  endtask

  task automatic burst_rd(input logic m);
    logic [15:0] b, ad [4];
    b = 16'h0045;
    burst_order_linear <= m;
    for (int k = 0; k < 4; k++)
    begin
      ad[k] = {b[15:2], m ? b[1:0] + k[1:0] : b[1:0] ^ k[1:0]};
      put(k == 0 ? (m ? 4'h7 : 4'hb) : 4'hd, b);
      if (k > 0) `CHK("rd_addr", ad[k-1], core_rd_addr)
      if (k == 1) `CHK("oe_first", 1'b0, dq_oe)
      if (k > 1) `CHK("dq", pat(ad[k-2]), dq_out)
      if (k > 1) `CHK("oe_on", 1'b1, dq_oe)
    end
    if (m) chip_select_b_n <= 1'b1;
    else chip_select_b_hi <= 1'b0;
    put(4'hb, b);
    `CHK("rd_addr", ad[3], core_rd_addr)
    `CHK("dq", pat(ad[2]), dq_out)
    put(4'hf, b);
    `CHK("dq", pat(ad[3]), dq_out)
    `CHK("rd_desel", 1'b0, core_rd_en)
    put(4'hf, b);
    `CHK("oe_off", 1'b0, dq_oe)
    chip_select_b_n <= 1'b0;
    chip_select_b_hi <= 1'b1;
  endtask

  task automatic snooze();
    sleep_request <= 1'b1;
    put(4'hf, 16'h0);
    put(4'hf, 16'h0);
    put(4'hb, 16'h0020);
    put(4'hf, 16'h0);
    `CHK("rd_in_sleep", 1'b0, core_rd_en)
    `CHK("sleep", 1'b1, sleep_active)
    sleep_request <= 1'b0;
    put(4'hf, 16'h0);
    put(4'hf, 16'h0);
    rd1(16'h0020, pat(16'h0020));
  endtask

  task automatic fill();
    stall <= 1'b1;
    for (int i = 0; i < 16; i++)
      wr(16'h0080 + i, 36'h0 + i, 1'b0, 4'hf);
    `CHK("full", 1'b0, write_buffer_ready)
    wr(16'h0090, 36'h1, 1'b0, 4'hf);
    stall <= 1'b0;
    for (int i = 0; i < 40 && core_wr_valid; i++)
      @(posedge mclk);
    `CHK("empty", 1'b0, core_wr_valid)
    rd1(16'h0090, pat(16'h0090));
    rd1(16'h008f, 36'hf);
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    burst_rd(1'b0);
    burst_rd(1'b1);
    wr(16'h0010, 36'h123456789, 1'b0, 4'hf);
    rd1(16'h0010, 36'h123456789);
    wr(16'h0011, 36'hfedcba987, 1'b1, 4'h0);
    rd1(16'h0011, 36'hfedcba987);
    wr(16'h0012, 36'h0aaaa5555, 1'b1, 4'ha);
    rd1(16'h0012, {9'h0b4, 9'h0aa, 9'h080, 9'h155});
    snooze();
    fill();
    close_out();
  end

  initial
  begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    close_out();
  end
endmodule
